// >>> src/efp_fifo_port.sv
// endpoint fifo programmed-i/o port: data window, byte count, fill state
// Behaviour
// - word write steps write pointer two, byte one
// - full max-packet count commits buffer automatically
// - word read steps read pointer two, byte one
// - fully read receive buffer empties itself
// - force flush drops one half of indexed buffer, committed head first
// - window reaches indexed fifo, upper byte high
// - max-packet write reloads byte count register
// - usb bus reset zeroes byte count
// - programmed short count commits packet automatically
// - short count commit only for programmed access
// - out acknowledge loads received byte count
// - odd final byte sits on lower lane
// - fill state reports double-buffer occupancy
// - fill state meaningless for control endpoint
// - force commit readies current transmit contents
`timescale 1ns/1ps
module efp_fifo_port
  import efp_pkg::*;
(
  input wire logic CLK_SYS_I,
  input wire logic SYS_RST_I,
  input wire logic USB_BUS_RST_I,
  input wire logic [3:0] EP_INDEX_I,
  input wire logic [7:0] BUS_ADDR_I,
  input wire logic [15:0] BUS_WDATA_I,
  input wire logic BUS_WR_I,
  input wire logic BUS_RD_I,
  input wire logic BUS_WORD_I,
  input wire logic MAX_PKT_WR_I,
  input wire logic [10:0] MAX_PKT_I,
  input wire logic FORCE_IN_COMMIT_I,
  input wire logic FORCE_FIFO_FLUSH_I,
  input wire logic [3:0] SIE_EP_I,
  input wire logic [5:0] SIE_ADDR_I,
  input wire logic SIE_WR_I,
  input wire logic [7:0] SIE_WDATA_I,
  input wire logic SIE_OUT_ACK_I,
  input wire logic [6:0] SIE_OUT_LEN_I,
  input wire logic SIE_IN_DONE_I,
  output logic [15:0] BUS_RDATA_O,
  output logic [7:0] SIE_RDATA_O,
  output logic SIE_TX_READY_O,
  output logic [6:0] SIE_TX_LEN_O,
  output logic SIE_RX_ROOM_O
);

  efp_state_t s_reg; // registered state
  efp_state_t s_next; // next state
  logic [7:0] mem [EFP_MEM_BYTES]; // byte store, slot/half/byte
  logic pw_lo; // processor writes lower byte
  logic pw_hi; // processor writes upper byte
  logic [10:0] pw_addr; // processor write address of lower byte

  // byte address of a slot, half and offset
  function automatic logic [10:0] mem_addr(logic [3:0] sl, logic half,
                                           logic [6:0] off);
    mem_addr = {sl, half, off[5:0]};
  endfunction

  // commit the half being filled and start a fresh one
  function automatic efp_slot_t commit_half(efp_slot_t s);
    efp_slot_t r;
    r = s;
    if (s.fill != 2'h2) begin
      r.len[s.head ^ s.fill[0]] = s.wr_ptr;
      r.fill = s.fill + 2'h1;
      r.wr_ptr = 7'h00;
    end
    commit_half = r;
  endfunction

  // retire the head half once drained or flushed
  function automatic efp_slot_t retire_head(efp_slot_t s);
    efp_slot_t r;
    r = s;
    if (s.fill != 2'h0) begin
      r.fill = s.fill - 2'h1;
      r.head = ~s.head;
    end
    r.rd_ptr = 7'h00;
    retire_head = r;
  endfunction

  // auto commit threshold: programmed short count, else max packet
  function automatic logic [6:0] commit_level(efp_slot_t s);
    logic [6:0] mps;
    mps = (s.max_pkt == 11'h000 || s.max_pkt > 11'(EFP_HALF_BYTES))
          ? EFP_HALF_BYTES_W : s.max_pkt[6:0];
    if (s.byte_count != 16'h0000 && s.byte_count < 16'(mps)) begin
      commit_level = s.byte_count[6:0];
    end else begin
      commit_level = mps;
    end
  endfunction

  // next state: sie events first, then processor access on the index
  always_comb begin
    efp_slot_t cur;
    efp_slot_t sie;
    logic is_in;
    logic [6:0] avail;
    logic [6:0] step;
    logic [6:0] room;
    s_next = s_reg;
    cur = '0;
    sie = '0;
    pw_lo = 1'b0;
    pw_hi = 1'b0;
    pw_addr = 11'h000;
    is_in = EP_INDEX_I[0];
    avail = 7'h00;
    step = 7'h00;
    room = 7'h00;
    // sie side: received packet committed, sent packet retired
    sie = s_next.slot[SIE_EP_I];
    if (SIE_OUT_ACK_I && sie.fill != 2'h2) begin
      sie.len[sie.head ^ sie.fill[0]] = SIE_OUT_LEN_I;
      sie.fill = sie.fill + 2'h1;
      sie.byte_count = {9'h000, SIE_OUT_LEN_I};
    end
    if (SIE_IN_DONE_I) begin
      sie = retire_head(sie);
    end
    s_next.slot[SIE_EP_I] = sie;
    // processor side acts on the indexed slot only
    cur = s_next.slot[EP_INDEX_I];
    if (MAX_PKT_WR_I) begin
      cur.max_pkt = MAX_PKT_I;
      cur.byte_count = {5'h00, MAX_PKT_I};
    end
    if (BUS_WR_I && BUS_ADDR_I == EFP_ADDR_BYTE_COUNT) begin
      // byte write touches the low byte only
      if (BUS_WORD_I) begin
        cur.byte_count = BUS_WDATA_I;
      end else begin
        cur.byte_count[7:0] = BUS_WDATA_I[7:0];
      end
    end
    // writes to the fill state address fall through untouched
    // transmit path; the only processor fill path, the sie fills receive halves, no dma here
    if (BUS_WR_I && BUS_ADDR_I == EFP_ADDR_DATA_WIN && is_in &&
        cur.fill != 2'h2) begin
      room = EFP_HALF_BYTES_W - cur.wr_ptr;
      step = (BUS_WORD_I && room > 7'h01) ? 7'h02 : 7'h01;
      pw_addr = mem_addr(EP_INDEX_I, cur.head ^ cur.fill[0], cur.wr_ptr);
      pw_lo = 1'b1;
      pw_hi = step == 7'h02;
      cur.wr_ptr = cur.wr_ptr + step;
      if (cur.wr_ptr >= commit_level(cur)) begin
        cur = commit_half(cur);
      end
    end
    // receive path: step read pointer, retire when drained
    if (BUS_RD_I && BUS_ADDR_I == EFP_ADDR_DATA_WIN && !is_in &&
        cur.fill != 2'h0) begin
      avail = cur.len[cur.head] - cur.rd_ptr;
      step = (BUS_WORD_I && avail > 7'h01) ? 7'h02 : 7'h01;
      cur.rd_ptr = cur.rd_ptr + step;
      if (cur.rd_ptr >= cur.len[cur.head]) begin
        cur = retire_head(cur);
      end
    end
    if (FORCE_IN_COMMIT_I && is_in) begin
      cur = commit_half(cur);
    end
    if (FORCE_FIFO_FLUSH_I) begin
      // drop a committed half, else the partly filled one
      if (cur.fill != 2'h0) begin
        cur = retire_head(cur);
      end else begin
        cur.wr_ptr = 7'h00;
        cur.rd_ptr = 7'h00;
      end
    end
    s_next.slot[EP_INDEX_I] = cur;
    // usb bus reset zeroes counts and drops pending data
    if (USB_BUS_RST_I) begin
      for (int i = 0; i < EFP_SLOTS; i++) begin
        s_next.slot[i].byte_count = EFP_BYTE_COUNT_RST;
        s_next.slot[i].fill = 2'h0;
        s_next.slot[i].wr_ptr = 7'h00;
        s_next.slot[i].rd_ptr = 7'h00;
      end
    end
    // read data for the processor, valid the cycle after the strobe
    s_next.bus_rdata = 16'h0000;
    if (BUS_RD_I) begin
      cur = s_reg.slot[EP_INDEX_I];
      unique case (BUS_ADDR_I)
        EFP_ADDR_BYTE_COUNT: begin
          s_next.bus_rdata = cur.byte_count;
        end
        EFP_ADDR_FILL_STATE: begin
          // control slots 0 and 1 always read as empty
          if (EP_INDEX_I[3:1] != 3'h0) begin
            s_next.bus_rdata[EFP_FILL_LSB +: 2] =
              (cur.fill == 2'h0) ? EFP_FILL_NONE :
              (cur.fill == 2'h1) ? EFP_FILL_ONE : EFP_FILL_BOTH;
          end
          // bits 15..2 stay zero
        end
        EFP_ADDR_DATA_WIN: begin
          if (!is_in && cur.fill != 2'h0) begin
            avail = cur.len[cur.head] - cur.rd_ptr;
            s_next.bus_rdata[EFP_LOWER_LSB +: 8] =
              mem[mem_addr(EP_INDEX_I, cur.head, cur.rd_ptr)];
            // odd last byte: upper lane reads zero
            if (BUS_WORD_I && avail > 7'h01) begin
              s_next.bus_rdata[EFP_UPPER_LSB +: 8] =
                mem[mem_addr(EP_INDEX_I, cur.head,
                             cur.rd_ptr + 7'h01)];
            end
          end
        end
        default: begin
          s_next.bus_rdata = EFP_DATA_WIN_RST;
        end
      endcase
    end
    // sie view of its selected slot
    sie = s_reg.slot[SIE_EP_I];
    s_next.sie_rdata = mem[mem_addr(SIE_EP_I, sie.head, {1'b0, SIE_ADDR_I})];
    s_next.tx_ready = sie.fill != 2'h0;
    s_next.tx_len = sie.len[sie.head];
    s_next.rx_room = sie.fill != 2'h2;
  end

  // state register; reset leaves every slot empty and counts zero
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // byte store: no reset, contents are undefined until written
  always_ff @(posedge CLK_SYS_I) begin
    if (SIE_WR_I) begin
      // sie fills the half that follows the committed ones
      mem[mem_addr(SIE_EP_I, s_reg.slot[SIE_EP_I].head ^
                   s_reg.slot[SIE_EP_I].fill[0], {1'b0, SIE_ADDR_I})]
        <= SIE_WDATA_I;
    end
    if (pw_lo) begin
      mem[pw_addr] <= BUS_WDATA_I[EFP_LOWER_LSB +: 8];
    end
    if (pw_hi) begin
      mem[pw_addr + 11'h001] <= BUS_WDATA_I[EFP_UPPER_LSB +: 8];
    end
  end

  // outputs straight from the state register
  assign BUS_RDATA_O = s_reg.bus_rdata;
  assign SIE_RDATA_O = s_reg.sie_rdata;
  assign SIE_TX_READY_O = s_reg.tx_ready;
  assign SIE_TX_LEN_O = s_reg.tx_len;
  assign SIE_RX_ROOM_O = s_reg.rx_room;

endmodule

// >>> src/efp_pkg.sv
// shared constants and types for the endpoint fifo programmed-i/o port
package efp_pkg;

  // register byte addresses on the processor bus
  localparam logic [7:0] EFP_ADDR_BYTE_COUNT = 8'h1C;
  localparam logic [7:0] EFP_ADDR_FILL_STATE = 8'h1E;
  localparam logic [7:0] EFP_ADDR_DATA_WIN = 8'h20;

  // reset values
  localparam logic [15:0] EFP_BYTE_COUNT_RST = 16'h0000;
  localparam logic [7:0] EFP_FILL_STATE_RST = 8'h00;
  localparam logic [15:0] EFP_DATA_WIN_RST = 16'h0000;

  // field positions: data window lanes, fill state bits
  localparam int EFP_UPPER_LSB = 8;
  localparam int EFP_LOWER_LSB = 0;
  localparam int EFP_FILL_LSB = 0;

  // fill state encodings
  localparam logic [1:0] EFP_FILL_NONE = 2'h0;
  localparam logic [1:0] EFP_FILL_ONE = 2'h1;
  localparam logic [1:0] EFP_FILL_BOTH = 2'h3;

  // buffer geometry: 16 index slots, two halves each, 64 bytes a half
  localparam int EFP_SLOTS = 16;
  localparam int EFP_HALF_BYTES = 64;
  localparam logic [6:0] EFP_HALF_BYTES_W = 7'h40;
  localparam int EFP_MEM_BYTES = 2048;

  // processor wait times, kept by the processor side
  localparam int EFP_CLK_PERIOD_PS = 25000;
  localparam int EFP_IDX_TO_RD_NS = 190;
  localparam int EFP_IDX_TO_WR_NS = 100;
  localparam int EFP_WR_TO_FILL_NS = 200;
  localparam int EFP_IRQ_TO_FILL_NS = 200;
  localparam int EFP_IDX_TO_RD_CYC =
    (EFP_IDX_TO_RD_NS * 1000 + EFP_CLK_PERIOD_PS - 1) / EFP_CLK_PERIOD_PS;
  localparam int EFP_IDX_TO_WR_CYC =
    (EFP_IDX_TO_WR_NS * 1000 + EFP_CLK_PERIOD_PS - 1) / EFP_CLK_PERIOD_PS;
  localparam int EFP_WR_TO_FILL_CYC =
    (EFP_WR_TO_FILL_NS * 1000 + EFP_CLK_PERIOD_PS - 1) / EFP_CLK_PERIOD_PS;
  localparam int EFP_IRQ_TO_FILL_CYC =
    (EFP_IRQ_TO_FILL_NS * 1000 + EFP_CLK_PERIOD_PS - 1) / EFP_CLK_PERIOD_PS;

  // per index slot bookkeeping
  typedef struct packed {
    logic [6:0] wr_ptr;        // bytes in the half being filled
    logic [6:0] rd_ptr;        // bytes consumed from the head half
    logic [1:0] fill;          // committed halves, 0..2
    logic head;                // half drained next
    logic [1:0][6:0] len;      // committed length of each half
    logic [15:0] byte_count;   // packet byte count register
    logic [10:0] max_pkt;      // configured fifo size
  } efp_slot_t;

  // complete module state
  typedef struct packed {
    efp_slot_t [EFP_SLOTS-1:0] slot;
    logic [15:0] bus_rdata;
    logic [7:0] sie_rdata;
    logic tx_ready;
    logic [6:0] tx_len;
    logic rx_room;
  } efp_state_t;

endpackage

// >>> sim/efp_fifo_port_checker.sv
// concurrent checks on the pins of the endpoint fifo port
`timescale 1ns/1ps
module efp_fifo_port_checker
  import efp_pkg::*;
(
  input wire logic CLK_SYS_I,
  input wire logic SYS_RST_I,
  input wire logic USB_BUS_RST_I,
  input wire logic [3:0] EP_INDEX_I,
  input wire logic [7:0] BUS_ADDR_I,
  input wire logic BUS_WR_I,
  input wire logic BUS_RD_I,
  input wire logic MAX_PKT_WR_I,
  input wire logic [10:0] MAX_PKT_I,
  input wire logic FORCE_IN_COMMIT_I,
  input wire logic SIE_OUT_ACK_I,
  input wire logic [15:0] BUS_RDATA_O,
  input wire logic SIE_TX_READY_O,
  input wire logic SIE_RX_ROOM_O
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (SYS_RST_I);
  // read data stands one cycle, then returns to zero
  property p_rd_idle;
    !BUS_RD_I |=> BUS_RDATA_O == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
  // upper fill bits are reserved
  property p_fill_rsv;
    BUS_RD_I && BUS_ADDR_I == 8'h1E |=> BUS_RDATA_O[15:2] == 14'h0000;
  endproperty
  a_fill_rsv: assert property (p_fill_rsv) else $error("fill rsv");
  // control slots report nothing
  property p_fill_ctl;
    BUS_RD_I && BUS_ADDR_I == 8'h1E && EP_INDEX_I[3:1] == 3'h0
      |=> BUS_RDATA_O == 16'h0000;
  endproperty
  a_fill_ctl: assert property (p_fill_ctl) else $error("fill ctl");
  // only the three documented codes ever show
  property p_fill_code;
    BUS_RD_I && BUS_ADDR_I == 8'h1E |=> BUS_RDATA_O[1:0] != 2'h2;
  endproperty
  a_fill_code: assert property (p_fill_code) else $error("fill code");
  // quiet cycle between, so no other update can mask the clear
  property p_cnt_busrst;
    USB_BUS_RST_I ##1 !BUS_WR_I && !MAX_PKT_WR_I && !SIE_OUT_ACK_I
      ##1 BUS_RD_I && BUS_ADDR_I == 8'h1C |=> BUS_RDATA_O == 16'h0000;
  endproperty
  a_cnt_busrst: assert property (p_cnt_busrst) else $error("cnt rst");
  // bus reset leaves the slot on SIE_EP_I empty two cycles on, unless refilled
  property p_busrst_empty;
    USB_BUS_RST_I ##1 !SIE_OUT_ACK_I && !BUS_WR_I && !FORCE_IN_COMMIT_I
      |=> !SIE_TX_READY_O && SIE_RX_ROOM_O;
  endproperty
  a_busrst_empty: assert property (p_busrst_empty) else $error("rst fill");
  // size write reloads the count of the same slot
  property p_mpk_reload;
    MAX_PKT_WR_I && !BUS_WR_I && !SIE_OUT_ACK_I && !USB_BUS_RST_I
      ##1 !BUS_WR_I && !SIE_OUT_ACK_I && !USB_BUS_RST_I && !MAX_PKT_WR_I
      && $stable(EP_INDEX_I) ##1 BUS_RD_I && BUS_ADDR_I == 8'h1C
      && $stable(EP_INDEX_I) |=> BUS_RDATA_O == {5'h00, $past(MAX_PKT_I, 3)};
  endproperty
  a_mpk_reload: assert property (p_mpk_reload) else $error("reload");
  // an empty slot always has room; skip the edge right after reset
  property p_ready_room;
    !$past(SYS_RST_I) && !SIE_TX_READY_O |-> SIE_RX_ROOM_O;
  endproperty
  a_ready_room: assert property (p_ready_room) else $error("room");
  c_fill_rd: cover property (BUS_RD_I && BUS_ADDR_I == 8'h1E);
  c_out_ack: cover property (SIE_OUT_ACK_I);
  c_commit: cover property (FORCE_IN_COMMIT_I);
endmodule
bind efp_fifo_port efp_fifo_port_checker chk (.*);

// >>> sim/efp_sie_model.sv
// usb engine stand-in: fills out packets and retires in packets
`timescale 1ns/1ps
module efp_sie_model (
  input wire logic clk_i,
  output logic [3:0] ep_o,
  output logic [5:0] addr_o,
  output logic wr_o,
  output logic [7:0] wdata_o,
  output logic ack_o,
  output logic [6:0] len_o,
  output logic done_o
);
  // idle at start
  initial begin
    {ep_o, addr_o, wr_o, wdata_o, ack_o, len_o, done_o} = '0;
  end
  // point the status outputs at one slot
  task automatic pick(logic [3:0] ep);
    @(posedge clk_i);
    ep_o <= ep;
  endtask
  // bytes first, acknowledge after; data line flips once released
  task automatic rx_pkt(logic [3:0] ep, int n, logic [7:0] b);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      ep_o <= ep;
      addr_o <= 6'(i);
      wr_o <= 1'b1;
      wdata_o <= b + 8'(i);
    end
    @(posedge clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~wdata_o;
    ack_o <= 1'b1;
    len_o <= 7'(n);
    @(posedge clk_i);
    ack_o <= 1'b0;
  endtask
  // in packet sent: head half freed
  task automatic retire(logic [3:0] ep);
    @(posedge clk_i);
    ep_o <= ep;
    done_o <= 1'b1;
    @(posedge clk_i);
    done_o <= 1'b0;
  endtask
endmodule

// >>> sim/tb_top.sv
// self-checking bench for the endpoint fifo port
`timescale 1ns/1ps
module tb_top import efp_pkg::*;;
  logic CLK_SYS_I = 1'b0;
  logic SYS_RST_I = 1'b1;
  logic USB_BUS_RST_I = 1'b0;
  logic [3:0] EP_INDEX_I = 4'h0;
  logic [7:0] BUS_ADDR_I = 8'h00;
  logic [15:0] BUS_WDATA_I = 16'h0000;
  logic BUS_WR_I = 1'b0;
  logic BUS_RD_I = 1'b0;
  logic BUS_WORD_I = 1'b0;
  logic MAX_PKT_WR_I = 1'b0;
  logic [10:0] MAX_PKT_I = 11'h000;
  logic FORCE_IN_COMMIT_I = 1'b0;
  logic FORCE_FIFO_FLUSH_I = 1'b0;
  logic [3:0] SIE_EP_I;
  logic [5:0] SIE_ADDR_I;
  logic SIE_WR_I;
  logic [7:0] SIE_WDATA_I;
  logic SIE_OUT_ACK_I;
  logic [6:0] SIE_OUT_LEN_I;
  logic SIE_IN_DONE_I;
  logic [15:0] BUS_RDATA_O;
  logic [7:0] SIE_RDATA_O;
  logic SIE_TX_READY_O;
  logic [6:0] SIE_TX_LEN_O;
  logic SIE_RX_ROOM_O;
  int n_fail = 0;
  int checks = 0;
  always #12.5 CLK_SYS_I = ~CLK_SYS_I;
  efp_fifo_port dut (.*);
  efp_sie_model sie (.clk_i(CLK_SYS_I), .ep_o(SIE_EP_I), .addr_o(SIE_ADDR_I),
    .wr_o(SIE_WR_I), .wdata_o(SIE_WDATA_I), .ack_o(SIE_OUT_ACK_I),
    .len_o(SIE_OUT_LEN_I), .done_o(SIE_IN_DONE_I));
  // compare and count
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // one bus access; a read compares against d
  task automatic acc(logic r, logic [7:0] a, logic w, logic [15:0] d);
    @(posedge CLK_SYS_I);
    BUS_RD_I <= r;
    BUS_WR_I <= !r;
    BUS_ADDR_I <= a;
    BUS_WORD_I <= w;
    BUS_WDATA_I <= d;
    @(posedge CLK_SYS_I);
    BUS_RD_I <= 1'b0;
    BUS_WR_I <= 1'b0;
    #1;
    if (r) chk("rdata", BUS_RDATA_O, d);
  endtask
  // index change, then the processor's settle time
  task automatic sel(logic [3:0] v);
    @(posedge CLK_SYS_I);
    EP_INDEX_I <= v;
    repeat (EFP_IDX_TO_RD_CYC) @(posedge CLK_SYS_I);
  endtask
  // one-cycle control pulse: bits are size write, commit, flush, bus reset
  task automatic pulse(logic [3:0] m);
    @(posedge CLK_SYS_I);
    {MAX_PKT_WR_I, FORCE_IN_COMMIT_I, FORCE_FIFO_FLUSH_I, USB_BUS_RST_I} <= m;
    @(posedge CLK_SYS_I);
    {MAX_PKT_WR_I, FORCE_IN_COMMIT_I, FORCE_FIFO_FLUSH_I, USB_BUS_RST_I} <=
      4'h0;
  endtask
  // wait long enough for fill state and status outputs to settle
  task automatic hold();
    repeat (EFP_WR_TO_FILL_CYC) @(posedge CLK_SYS_I);
    #1;
  endtask
  task automatic stop_test();
    $display("checks %0d failures %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // hang guard, far beyond the expected run
  initial begin
    repeat (5000) @(posedge CLK_SYS_I);
    n_fail++;
    stop_test();
  end
  initial begin
    repeat (5) @(posedge CLK_SYS_I);
    SYS_RST_I <= 1'b0;
    sel(4'h3);
    acc(1, 8'h1C, 1, 16'h0000);
    acc(0, 8'h1E, 1, 16'hFFFF);
    acc(1, 8'h1E, 1, 16'h0000);
    acc(1, 8'h40, 1, 16'h0000);
    $display("test reset done");
    @(posedge CLK_SYS_I);
    MAX_PKT_I <= 11'h010;
    pulse(4'h8);
    acc(1, 8'h1C, 1, 16'h0010);
    sie.pick(4'h3);
    for (int i = 0; i < 7; i++) begin
      acc(0, 8'h20, 1, {8'(8'h51 + 2 * i), 8'(8'h50 + 2 * i)});
    end
    acc(0, 8'h20, 0, 16'h005E);
    hold();
    chk("ready", {15'h0, SIE_TX_READY_O}, 16'h0000);
    acc(0, 8'h20, 0, 16'h005F);
    hold();
    chk("ready", {15'h0, SIE_TX_READY_O}, 16'h0001);
    chk("len", {9'h0, SIE_TX_LEN_O}, 16'h0010);
    chk("byte0", {8'h0, SIE_RDATA_O}, 16'h0050);
    acc(1, 8'h1E, 1, 16'h0001);
    for (int i = 0; i < 3; i++) begin
      acc(0, 8'h20, 0, 16'h0077);
    end
    pulse(4'h4);
    hold();
    acc(1, 8'h1E, 1, 16'h0003);
    sie.retire(4'h3);
    hold();
    acc(1, 8'h1E, 1, 16'h0001);
    chk("len", {9'h0, SIE_TX_LEN_O}, 16'h0003);
    pulse(4'h2);
    hold();
    acc(1, 8'h1E, 1, 16'h0000);
    acc(0, 8'h1C, 1, 16'h0005);
    acc(0, 8'h20, 1, 16'h1211);
    acc(0, 8'h20, 1, 16'h1413);
    hold();
    chk("ready", {15'h0, SIE_TX_READY_O}, 16'h0000);
    acc(0, 8'h20, 0, 16'h0015);
    hold();
    chk("ready", {15'h0, SIE_TX_READY_O}, 16'h0001);
    chk("len", {9'h0, SIE_TX_LEN_O}, 16'h0005);
    $display("test in done");
    sel(4'h2);
    sie.rx_pkt(4'h2, 5, 8'h30);
    hold();
    acc(1, 8'h1C, 1, 16'h0005);
    acc(1, 8'h1E, 1, 16'h0001);
    acc(1, 8'h20, 1, 16'h3130);
    acc(1, 8'h20, 1, 16'h3332);
    acc(1, 8'h20, 1, 16'h0034);
    hold();
    acc(1, 8'h1E, 1, 16'h0000);
    acc(1, 8'h20, 1, 16'h0000);
    sie.rx_pkt(4'h2, 3, 8'h40);
    sie.rx_pkt(4'h2, 2, 8'h50);
    hold();
    acc(1, 8'h1E, 1, 16'h0003);
    chk("room", {15'h0, SIE_RX_ROOM_O}, 16'h0000);
    acc(1, 8'h20, 0, 16'h0040);
    acc(1, 8'h20, 0, 16'h0041);
    pulse(4'h2);
    pulse(4'h2);
    hold();
    acc(1, 8'h1E, 1, 16'h0000);
    sel(4'h3);
    acc(1, 8'h1C, 1, 16'h0005);
    acc(0, 8'h1C, 0, 16'hAB07);
    acc(1, 8'h1C, 1, 16'h0007);
    $display("test out done");
    sel(4'h0);
    sie.rx_pkt(4'h0, 1, 8'h11);
    hold();
    acc(1, 8'h1E, 1, 16'h0000);
    sel(4'h2);
    sie.rx_pkt(4'h2, 2, 8'h60);
    pulse(4'h1);
    acc(1, 8'h1C, 1, 16'h0000);
    acc(1, 8'h1E, 1, 16'h0000);
    $display("test bus reset done");
    stop_test();
  end
endmodule
